// ==== bench/cpu_call_skip_intctl_exec_tb.sv ====
// self-checking bench for the call, skip, interrupt-control and watchdog
// execution core; assumes the package and stack interface are compiled first
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
   $display("ERROR %0t: output mismatch got %h exp %h", $time, g, e); end end
module cpu_call_skip_intctl_exec_tb
   import ccsie_pkg::*;
;
   typedef struct packed {
      logic [PC_W-1:0] pc;
      logic [PC_W-1:0] top;
      logic [Y_W-1:0]  y;
      logic [2:0]      sp;
      logic            skip, flag, eff, acc, tv, run, arm, rs;
   } ccsie_note_t;

   logic            CLK_SYS = 1'b0;
   logic            RST = 1'b1;
   logic            OP_VALID = 1'b0;
   ccsie_op_t       OP_CODE = CCSIE_OP_OTHER;
   logic [6:0]      OP_PAGE = 7'h00;
   logic [2:0]      D_REG = 3'h0;
   logic [3:0]      A_REG = 4'h0;
   logic            Y_LOAD = 1'b0;
   logic [3:0]      Y_DATA = 4'h0;
   logic            IRQ_REQ = 1'b0;
   logic            IRQ_ACCEPT, SKIP_ACTIVE, GLOBAL_IRQ_ENABLE_FLAG;
   logic            IRQ_EFFECTIVE, STACK_OVERFLOW, WDT_STOP_ARMED;
   logic            WDT_RUNNING, WDT_RESTART;
   logic [6:0]      PC_PAGE_BITS, PC_INPAGE_BITS;
   logic [3:0]      Y_REG;
   logic [2:0]      STACK_POINTER;
   logic [13:0]     STACK_TOP;
   int              fail_count = 0;
   int              checks = 0;
   int              calls = 0;
   ccsie_note_t     q[$];
   logic            pend = 1'b0;
   // reference state, kept from the rules alone
   logic [13:0]     m_pc = PC_RST;
   logic [13:0]     m_top = 14'h0000;
   logic [3:0]      m_y = 4'h0;
   logic [2:0]      m_sp = 3'h7;
   logic            m_skip = 1'b0, m_flag = 1'b0, m_eff = 1'b0;
   logic            m_run = 1'b1, m_arm = 1'b0;

   ccsie_exec dut (
      .CLK_SYS, .RST, .OP_VALID, .OP_CODE, .OP_PAGE, .D_REG, .A_REG,
      .Y_LOAD, .Y_DATA, .IRQ_REQ, .IRQ_ACCEPT, .PC_PAGE_BITS,
      .PC_INPAGE_BITS, .Y_REG, .SKIP_ACTIVE, .GLOBAL_IRQ_ENABLE_FLAG,
      .IRQ_EFFECTIVE, .STACK_POINTER, .STACK_TOP, .STACK_OVERFLOW,
      .WDT_STOP_ARMED, .WDT_RUNNING, .WDT_RESTART
   );

   always #10 CLK_SYS = ~CLK_SYS;

   task automatic wrap_up();
      if (fail_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic idle();
      @(posedge CLK_SYS);
      #1;
      OP_VALID = 1'b0;
      IRQ_REQ = 1'b0;
      Y_LOAD = 1'b0;
   endtask

   // load Y between ops so that a decrement never competes with it
   task automatic load_y(logic [3:0] v);
      @(posedge CLK_SYS);
      #1;
      OP_VALID = 1'b0;
      IRQ_REQ = 1'b0;
      Y_LOAD = 1'b1;
      Y_DATA = v;
      m_y = v;
      idle();
   endtask

   task automatic do_op(ccsie_op_t op, logic irq);
      logic [6:0]  p;
      logic [2:0]  d;
      logic [3:0]  a;
      logic        old;
      ccsie_note_t n;
      p = 7'($urandom_range(95));
      d = 3'($urandom);
      a = 4'($urandom);
      if (op == CCSIE_OP_LONG_CALL_VIA_REGS && calls == STACK_DEPTH_DEF) begin
         op = CCSIE_OP_OTHER;
      end
      @(posedge CLK_SYS);
      #1;
      OP_VALID = 1'b1;
      OP_CODE = op;
      OP_PAGE = p;
      D_REG = d;
      A_REG = a;
      IRQ_REQ = irq;
      Y_LOAD = 1'b0;
      n = '0;
      old = m_flag;
      if (m_skip) begin
         m_pc += (op == CCSIE_OP_LONG_CALL_VIA_REGS) ? WORDS_CALL : WORDS_ONE;
         m_skip = 1'b0;
      end else begin
         n.acc = irq & m_eff;
         if (n.acc) m_flag = 1'b0;
         if (op == CCSIE_OP_LONG_CALL_VIA_REGS) begin
            m_sp++;
            m_top = m_pc + WORDS_CALL;
            m_pc = {p, d, a};
            calls++;
         end else begin
            m_pc += WORDS_ONE;
         end
         if (op == CCSIE_OP_DECREMENT_INDEX_Y) begin
            m_y--;
            m_skip = (m_y == Y_WRAP);
         end
         if (op == CCSIE_OP_INTERRUPT_DISABLE) m_flag = 1'b0;
         if (op == CCSIE_OP_INTERRUPT_ENABLE) m_flag = 1'b1;
         if (op == CCSIE_OP_WATCHDOG_STOP_ARM) m_arm = 1'b1;
         if (op == CCSIE_OP_WATCHDOG_RESTART) begin
            n.rs = ~m_arm;
            if (m_arm) m_run = 1'b0;
            m_arm = 1'b0;
         end
      end
      m_eff = old;
      n.pc = m_pc;
      n.top = m_top;
      n.tv = (calls > 0);
      n.y = m_y;
      n.sp = m_sp;
      n.skip = m_skip;
      n.flag = m_flag;
      n.eff = m_eff;
      n.run = m_run;
      n.arm = m_arm;
      q.push_back(n);
   endtask

   // result of an op is checked at the falling edge after the edge that took it
   always @(posedge CLK_SYS) pend <= OP_VALID & ~RST;

   always @(negedge CLK_SYS) begin
      ccsie_note_t n;
      if (pend && q.size() > 0) begin
         n = q.pop_front();
         `CHK(PC_PAGE_BITS, n.pc[13:7])
         `CHK(PC_INPAGE_BITS, n.pc[6:0])
         `CHK(Y_REG, n.y)
         `CHK(SKIP_ACTIVE, n.skip)
         `CHK(GLOBAL_IRQ_ENABLE_FLAG, n.flag)
         `CHK(IRQ_EFFECTIVE, n.eff)
         `CHK(IRQ_ACCEPT, n.acc)
         `CHK(STACK_POINTER, n.sp)
         if (n.tv) `CHK(STACK_TOP, n.top)
         `CHK(STACK_OVERFLOW, 1'b0)
         `CHK(WDT_RUNNING, n.run)
         `CHK(WDT_STOP_ARMED, n.arm)
         `CHK(WDT_RESTART, n.rs)
      end
   end

   initial begin
      repeat (3000) @(posedge CLK_SYS);
      fail_count++;
      wrap_up();
   end

   initial begin
      void'($urandom(32'h4BF8150A));
      repeat (5) @(posedge CLK_SYS);
      #1;
      RST = 1'b0;
      @(negedge CLK_SYS);
      `CHK({PC_PAGE_BITS, PC_INPAGE_BITS}, PC_RST)
      `CHK(WDT_RUNNING, WDT_RUN_RST)
      `CHK(GLOBAL_IRQ_ENABLE_FLAG, IRQ_EN_RST)
      load_y(4'h0);
      do_op(CCSIE_OP_DECREMENT_INDEX_Y, 1'b0);
      do_op(CCSIE_OP_LONG_CALL_VIA_REGS, 1'b1);
      do_op(CCSIE_OP_DECREMENT_INDEX_Y, 1'b0);
      do_op(CCSIE_OP_INTERRUPT_ENABLE, 1'b1);
      do_op(CCSIE_OP_OTHER, 1'b1);
      do_op(CCSIE_OP_OTHER, 1'b1);
      do_op(CCSIE_OP_INTERRUPT_ENABLE, 1'b0);
      do_op(CCSIE_OP_OTHER, 1'b0);
      do_op(CCSIE_OP_INTERRUPT_DISABLE, 1'b0);
      do_op(CCSIE_OP_OTHER, 1'b1);
      do_op(CCSIE_OP_OTHER, 1'b1);
      do_op(CCSIE_OP_WATCHDOG_RESTART, 1'b0);
      do_op(CCSIE_OP_WATCHDOG_STOP_ARM, 1'b0);
      do_op(CCSIE_OP_OTHER, 1'b0);
      do_op(CCSIE_OP_WATCHDOG_RESTART, 1'b0);
      repeat (3) do_op(CCSIE_OP_LONG_CALL_VIA_REGS, 1'b0);
      idle();
      // random back-to-back mix of every op, with loads of Y in between
      repeat (300) begin
         if ($urandom_range(7) == 0) load_y(4'($urandom));
         do_op(ccsie_op_t'($urandom_range(6)), 1'($urandom));
      end
      idle();
      repeat (3) @(posedge CLK_SYS);
      wrap_up();
   end
endmodule

// ==== core/ccsie_exec.sv ====
// execution core for long call via registers, decrement of Y with skip,
// interrupt enable/disable with a one-cycle delay and watchdog stopping
// assumes a decoder upstream presents one operation per OP_VALID strobe,
// each strobe being one machine cycle, all on CLK_SYS
`timescale 1ns/10ps
module ccsie_exec
   import ccsie_pkg::*;
#(
   parameter logic [PAGE_W-1:0] PAGE_MAX    = PAGE_MAX_LARGE,
   parameter int                STACK_DEPTH = STACK_DEPTH_DEF
)(
   // clock and reset
   input  wire logic               CLK_SYS,
   input  wire logic               RST,
   // decoded instruction
   input  wire logic               OP_VALID,
   input  wire ccsie_op_t          OP_CODE,
   input  wire logic [PAGE_W-1:0]  OP_PAGE,
   input  wire logic [D_W-1:0]     D_REG,
   input  wire logic [A_W-1:0]     A_REG,
   // index register load from other instructions
   input  wire logic               Y_LOAD,
   input  wire logic [Y_W-1:0]     Y_DATA,
   // interrupt request and acceptance
   input  wire logic               IRQ_REQ,
   output logic                    IRQ_ACCEPT,
   // core state
   output logic [PAGE_W-1:0]       PC_PAGE_BITS,
   output logic [INPAGE_W-1:0]     PC_INPAGE_BITS,
   output logic [Y_W-1:0]          Y_REG,
   output logic                    SKIP_ACTIVE,
   output logic                    GLOBAL_IRQ_ENABLE_FLAG,
   output logic                    IRQ_EFFECTIVE,
   output logic [$clog2(STACK_DEPTH)-1:0] STACK_POINTER,
   output logic [PC_W-1:0]         STACK_TOP,
   output logic                    STACK_OVERFLOW,
   // watchdog control
   output logic                    WDT_STOP_ARMED,
   output logic                    WDT_RUNNING,
   output logic                    WDT_RESTART
);
   localparam int SP_W = $clog2(STACK_DEPTH);

   // refused at elaboration: only the two variant page limits exist
   if (PAGE_MAX != PAGE_MAX_SMALL &&
       PAGE_MAX != PAGE_MAX_LARGE) begin : g_page_chk
      $error("PAGE_MAX must be one of the two variant limits");
   end

   ccsie_stack_if #(.SP_W(SP_W)) stk ();

   ccsie_stack #(.DEPTH(STACK_DEPTH)) u_stack (
      .clk (CLK_SYS),
      .rst (RST),
      .st  (stk.stack)
   );

   logic [PC_W-1:0]   pc;
   logic [PC_W-1:0]   next_pc;
   logic [Y_W-1:0]    y;
   logic [Y_W-1:0]    next_y;
   logic              skip;
   logic              next_skip;
   logic              irq_flag;
   logic              next_irq_flag;
   logic              irq_eff;
   logic              next_irq_eff;
   logic              accept;
   logic              next_accept;
   logic              wdt_armed;
   logic              next_wdt_armed;
   logic              wdt_run;
   logic              next_wdt_run;
   logic              wdt_kick;
   logic              next_wdt_kick;
   logic              exec;
   logic [PAGE_W-1:0] call_page;

   // a skipped slot executes nothing
   assign exec = OP_VALID && !skip;

   // the small variant has no page bit 6
   assign call_page = (PAGE_MAX == PAGE_MAX_SMALL) ?
                      {1'b0, OP_PAGE[PAGE_W-2:0]} : OP_PAGE;

   always_comb begin
      next_pc        = pc;
      next_y         = y;
      next_skip      = skip;
      next_irq_flag  = irq_flag;
      next_irq_eff   = irq_eff;
      next_accept    = 1'b0;
      next_wdt_armed = wdt_armed;
      next_wdt_run   = wdt_run;
      next_wdt_kick  = 1'b0;
      stk.push       = 1'b0;
      stk.push_addr  = pc + WORDS_CALL;
      if (Y_LOAD)
         next_y = Y_DATA;
      if (OP_VALID) begin
         // enable follows the flag one machine cycle late
         next_irq_eff = irq_flag;
         next_skip    = 1'b0;
         if (OP_CODE == CCSIE_OP_LONG_CALL_VIA_REGS)
            next_pc = pc + WORDS_CALL;
         else
            next_pc = pc + WORDS_ONE;
      end
      if (exec) begin
         if (IRQ_REQ && irq_eff) begin
            next_accept   = 1'b1;
            next_irq_flag = 1'b0;
         end
         case (OP_CODE)
            CCSIE_OP_LONG_CALL_VIA_REGS: begin
               stk.push = 1'b1;
               next_pc  = {call_page, D_REG, A_REG};
            end
            CCSIE_OP_DECREMENT_INDEX_Y: begin
               next_y    = y - 1'b1;
               next_skip = (y - 1'b1) == Y_WRAP;
            end
            CCSIE_OP_INTERRUPT_DISABLE: next_irq_flag = 1'b0;
            CCSIE_OP_INTERRUPT_ENABLE:  next_irq_flag = 1'b1;
            CCSIE_OP_WATCHDOG_STOP_ARM: next_wdt_armed = 1'b1;
            CCSIE_OP_WATCHDOG_RESTART: begin
               // stopping needs the arm op first; otherwise a plain restart
               if (wdt_armed) begin
                  next_wdt_run   = 1'b0;
                  next_wdt_armed = 1'b0;
               end else begin
                  next_wdt_kick = 1'b1;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         pc        <= PC_RST;
         y         <= Y_RST;
         skip      <= 1'b0;
         irq_flag  <= IRQ_EN_RST;
         irq_eff   <= IRQ_EN_RST;
         accept    <= 1'b0;
         wdt_armed <= 1'b0;
         wdt_run   <= WDT_RUN_RST;
         wdt_kick  <= 1'b0;
      end else begin
         pc        <= next_pc;
         y         <= next_y;
         skip      <= next_skip;
         irq_flag  <= next_irq_flag;
         irq_eff   <= next_irq_eff;
         accept    <= next_accept;
         wdt_armed <= next_wdt_armed;
         wdt_run   <= next_wdt_run;
         wdt_kick  <= next_wdt_kick;
      end
   end

   assign PC_PAGE_BITS           = pc[PC_W-1:INPAGE_W];
   assign PC_INPAGE_BITS         = pc[INPAGE_W-1:0];
   assign Y_REG                  = y;
   assign SKIP_ACTIVE            = skip;
   assign GLOBAL_IRQ_ENABLE_FLAG = irq_flag;
   assign IRQ_EFFECTIVE          = irq_eff;
   assign IRQ_ACCEPT             = accept;
   assign STACK_POINTER          = stk.stack_pointer;
   assign STACK_TOP              = stk.top;
   assign STACK_OVERFLOW         = stk.overflow;
   assign WDT_STOP_ARMED         = wdt_armed;
   assign WDT_RUNNING            = wdt_run;
   assign WDT_RESTART            = wdt_kick;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   AST_CALL_PUSH: assert property (
      exec && OP_CODE == CCSIE_OP_LONG_CALL_VIA_REGS |=>
      STACK_POINTER == SP_W'($past(STACK_POINTER) + 1'b1) &&
      STACK_TOP == $past(pc) + WORDS_CALL)
      else $error("long call did not push the return address");

   AST_CALL_TARGET: assert property (
      exec && OP_CODE == CCSIE_OP_LONG_CALL_VIA_REGS |=>
      PC_INPAGE_BITS == {$past(D_REG), $past(A_REG)} &&
      PC_PAGE_BITS <= PAGE_MAX)
      else $error("long call target wrong");

   AST_DEC_WRAP_SKIP: assert property (
      exec && OP_CODE == CCSIE_OP_DECREMENT_INDEX_Y && y == Y_RST |=>
      SKIP_ACTIVE && Y_REG == Y_WRAP)
      else $error("decrement from zero did not skip");

   AST_DEC_NO_SKIP: assert property (
      exec && OP_CODE == CCSIE_OP_DECREMENT_INDEX_Y && y != Y_RST |=>
      !SKIP_ACTIVE && Y_REG == $past(y) - 1'b1)
      else $error("decrement skipped without wrapping");

   AST_DISABLE_FLAG: assert property (
      exec && OP_CODE == CCSIE_OP_INTERRUPT_DISABLE |=>
      !GLOBAL_IRQ_ENABLE_FLAG)
      else $error("disable op left the flag set");

   AST_DISABLE_DELAY: assert property (
      exec && OP_CODE == CCSIE_OP_INTERRUPT_DISABLE && irq_flag |=>
      IRQ_EFFECTIVE ##1 (!IRQ_EFFECTIVE || !$past(OP_VALID)))
      else $error("disable took effect at the wrong cycle");

   AST_NO_ACCEPT_OFF: assert property (
      OP_VALID && !IRQ_EFFECTIVE |=> !IRQ_ACCEPT)
      else $error("interrupt accepted while not enabled");

   AST_ENABLE_DELAY: assert property (
      exec && OP_CODE == CCSIE_OP_INTERRUPT_ENABLE && !irq_flag |=>
      GLOBAL_IRQ_ENABLE_FLAG && !IRQ_EFFECTIVE)
      else $error("enable took effect without its delay");

   AST_WDT_STOP: assert property (
      exec && OP_CODE == CCSIE_OP_WATCHDOG_RESTART && wdt_armed |=>
      !WDT_RUNNING && !WDT_RESTART)
      else $error("armed restart did not stop the watchdog");

   AST_WDT_ARM_ONLY: assert property (
      exec && OP_CODE == CCSIE_OP_WATCHDOG_STOP_ARM && WDT_RUNNING |=>
      WDT_RUNNING && WDT_STOP_ARMED)
      else $error("arm op stopped the watchdog by itself");

   AST_SKIP_NO_EFFECT: assert property (
      OP_VALID && skip && !Y_LOAD |=>
      $stable(Y_REG) && $stable(STACK_POINTER) &&
      $stable(GLOBAL_IRQ_ENABLE_FLAG) && !IRQ_ACCEPT && !SKIP_ACTIVE)
      else $error("skipped instruction had an effect");

   COV_CALL: cover property (exec && OP_CODE == CCSIE_OP_LONG_CALL_VIA_REGS);
   COV_SKIP: cover property (OP_VALID && skip);
   COV_LATE_ACCEPT: cover property (
      exec && OP_CODE == CCSIE_OP_INTERRUPT_DISABLE && irq_flag ##1
      !skip && OP_VALID && IRQ_REQ);
   COV_WDT_STOP: cover property ($fell(WDT_RUNNING));

endmodule

// ==== core/ccsie_stack.sv ====
// return-address stack: pre-increment pointer, store at the new slot
// assumes one push at most per clock; pops belong to other instructions
`timescale 1ns/10ps
module ccsie_stack
   import ccsie_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH_DEF
)(
   // clock and reset
   input wire logic   clk,
   input wire logic   rst,
   // push port
   ccsie_stack_if.stack st
);
   localparam int SP_W = $clog2(DEPTH);
   localparam logic [SP_W-1:0] SP_RST = '1;
   localparam logic [SP_W:0]   FILL_MAX = (SP_W+1)'(DEPTH);

   // refused at elaboration: the pointer wraps by its own width
   if (DEPTH < 2 || (1 << SP_W) != DEPTH) begin : g_depth_chk
      $error("stack depth must be a power of two, at least 2");
   end

   logic [PC_W-1:0] mem [DEPTH];
   logic [SP_W-1:0] sp;
   logic [SP_W-1:0] next_sp;
   logic [SP_W:0]   fill;
   logic [SP_W:0]   next_fill;
   logic            ovf;
   logic            next_ovf;

   always_comb begin
      next_sp   = sp;
      next_fill = fill;
      next_ovf  = ovf;
      if (st.push) begin
         next_sp = sp + 1'b1;
         // a push past full overwrites the oldest return address
         if (fill == FILL_MAX)
            next_ovf = 1'b1;
         else
            next_fill = fill + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sp   <= SP_RST;
         fill <= '0;
         ovf  <= 1'b0;
      end else begin
         sp   <= next_sp;
         fill <= next_fill;
         ovf  <= next_ovf;
      end
   end

   // storage needs no reset; the fill count tells valid slots
   always_ff @(posedge clk) begin
      if (st.push)
         mem[next_sp] <= st.push_addr;
   end

   assign st.stack_pointer = sp;
   assign st.top           = mem[sp];
   assign st.overflow      = ovf;

endmodule

// ==== include/ccsie_pkg.sv ====
// constants and types for the call, skip, interrupt-control and watchdog
// execution group; shared by the exec core and its return stack
package ccsie_pkg;

   // program counter layout: page in the high bits, in-page address low
   localparam int PAGE_W   = 7;
   localparam int INPAGE_W = 7;
   localparam int PC_W     = PAGE_W + INPAGE_W;
   localparam int D_W      = 3;
   localparam int A_W      = 4;
   localparam int Y_W      = 4;

   // page limits of the two variants
   localparam logic [PAGE_W-1:0] PAGE_MAX_SMALL = 7'h3F;
   localparam logic [PAGE_W-1:0] PAGE_MAX_LARGE = 7'h5F;

   // word counts; the long call is two words
   localparam logic [PC_W-1:0] WORDS_ONE  = 14'h0001;
   localparam logic [PC_W-1:0] WORDS_CALL = 14'h0002;

   // decrement wraps from zero to this value and then skips
   localparam logic [Y_W-1:0] Y_WRAP = 4'hF;

   // values after reset
   localparam logic [PC_W-1:0] PC_RST     = 14'h0000;
   localparam logic [Y_W-1:0]  Y_RST      = 4'h0;
   localparam logic            IRQ_EN_RST = 1'b0;
   localparam logic            WDT_RUN_RST = 1'b1;
   localparam int              STACK_DEPTH_DEF = 8;

   // decoded operations handed to the core, one per machine cycle
   typedef enum logic [2:0] {
      CCSIE_OP_OTHER,
      CCSIE_OP_LONG_CALL_VIA_REGS,
      CCSIE_OP_DECREMENT_INDEX_Y,
      CCSIE_OP_INTERRUPT_DISABLE,
      CCSIE_OP_INTERRUPT_ENABLE,
      CCSIE_OP_WATCHDOG_STOP_ARM,
      CCSIE_OP_WATCHDOG_RESTART
   } ccsie_op_t;

endpackage

// ==== include/ccsie_stack_if.sv ====
// push port between the exec core and its return-address stack
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface ccsie_stack_if #(parameter int SP_W = 3);
   import ccsie_pkg::*;
   logic              push;
   logic [PC_W-1:0]   push_addr;
   logic [SP_W-1:0]   stack_pointer;
   logic [PC_W-1:0]   top;
   logic              overflow;
   modport core  (output push, push_addr,
                  input  stack_pointer, top, overflow);
   modport stack (input  push, push_addr,
                  output stack_pointer, top, overflow);
endinterface
